// >>> rtl/tpw_defs.svh
// Notes on behaviour
// - Mode 8 tops at capture, 9 at compare A.
// - Dual slope counts zero to TOP and back.
// - Count stays at TOP exactly one tick.
// - Frequency-correct modes load compares and overflow at zero.
// - Capture or compare A flag set at TOP.
// - Match flag set when count equals compare.
// - Dual slope: action 10 clears up, sets down.
// - Action 01 toggles A in PWM modes only in 8 to 11, 14 and 15.
// - Action 00 leaves pin under port control.
// - Non-PWM: 01 toggles, 10 clears, 11 sets.
// - Fast PWM: 10 clears at match, sets at TOP.
// - Fast PWM compare equal TOP: act only at TOP.
// - Connected action overrides port; direction enables driver.
// - Dual slope: zero holds low, TOP holds high.
// - Control A layout; bits 3:2 read zero.
// - Counter advances only on timer tick.
// - Tick divides clock by 1, 8, 64, 256, 1024.
// - Control B bits 4:3 hold upper mode bits.
// - Modes 10 and 11 load compares at TOP.
`ifndef TPW_DEFS_SVH
`define TPW_DEFS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define TPW_ADDR_CTRL_A 3'h0
`define TPW_ADDR_CTRL_B 3'h1
`define TPW_ADDR_COUNT 3'h2
`define TPW_ADDR_CMP_A 3'h3
`define TPW_ADDR_CMP_B 3'h4
`define TPW_ADDR_CAPTOP 3'h5
`define TPW_ADDR_FLAGS 3'h6

`define TPW_CA_ACT_A 7:6
`define TPW_CA_ACT_B 5:4
`define TPW_CA_MODE_LO 1:0
`define TPW_CA_RSVD 3:2
`define TPW_CB_MODE_HI 4:3
`define TPW_CB_CLKSEL 2:0
`define TPW_FLG_OVF 0
`define TPW_FLG_CMPA 1
`define TPW_FLG_CMPB 2
`define TPW_FLG_CAPT 3

`define TPW_CTRL_A_RST 8'h00
`define TPW_CTRL_B_RST 5'h00
`define TPW_WORD_RST 16'h0000
`define TPW_FLAGS_RST 4'h0

// ****************************************************************
// Waveform modes, actions and fixed TOP values
// ****************************************************************
`define TPW_MODE_NORMAL 4'h0
`define TPW_MODE_PC8 4'h1
`define TPW_MODE_PC9 4'h2
`define TPW_MODE_PC10 4'h3
`define TPW_MODE_CTC_A 4'h4
`define TPW_MODE_FP8 4'h5
`define TPW_MODE_FP9 4'h6
`define TPW_MODE_FP10 4'h7
`define TPW_MODE_PFC_CAP 4'h8
`define TPW_MODE_PFC_A 4'h9
`define TPW_MODE_PC_CAP 4'ha
`define TPW_MODE_PC_A 4'hb
`define TPW_MODE_CTC_CAP 4'hc
`define TPW_MODE_FP_CAP 4'he
`define TPW_MODE_FP_A 4'hf

`define TPW_ACT_OFF 2'h0
`define TPW_ACT_TOGGLE 2'h1
`define TPW_ACT_CLEAR 2'h2
`define TPW_ACT_SET 2'h3

`define TPW_TOP_8BIT 16'h00ff
`define TPW_TOP_9BIT 16'h01ff
`define TPW_TOP_10BIT 16'h03ff
`define TPW_TOP_MAX 16'hffff
`define TPW_BOTTOM 16'h0000
`define TPW_ONE 16'h0001

// ****************************************************************
// Prescaler
// ****************************************************************
`define TPW_CS_DIV1 3'h1
`define TPW_CS_DIV8 3'h2
`define TPW_CS_DIV64 3'h3
`define TPW_CS_DIV256 3'h4
`define TPW_CS_DIV1024 3'h5
`define TPW_PS_MASK_8 10'h007
`define TPW_PS_MASK_64 10'h03f
`define TPW_PS_MASK_256 10'h0ff
`define TPW_PS_MASK_1024 10'h3ff
`define TPW_PS_RST 10'h000

`endif

// >>> rtl/tpw_pkg.sv
`include "tpw_defs.svh"

package tpw_pkg;

  typedef enum logic {TPW_UP, TPW_DOWN} tpw_dir_t;
  typedef enum logic [1:0] {TPW_CL_NONPWM, TPW_CL_FAST, TPW_CL_DUAL, TPW_CL_RSVD} tpw_class_t;
  typedef enum logic [1:0] {TPW_UPD_NOW, TPW_UPD_TOP, TPW_UPD_BOTTOM} tpw_upd_t;

  typedef struct packed {
    logic [9:0] div;
    logic tick;
  } tpw_pre_t;

  typedef struct packed {
    logic [15:0] buffer;
    logic [15:0] active;
    logic oc;
  } tpw_chan_t;

  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [4:0] ctrl_b;
    logic [15:0] count;
    tpw_dir_t dir;
    logic [15:0] capture_top;
    logic [3:0] flags;
    logic [15:0] rdata;
    logic pin_a;
    logic pin_a_oe;
    logic pin_b;
    logic pin_b_oe;
  } tpw_main_t;

  function automatic tpw_class_t tpw_class_of(input logic [3:0] mode);
    case (mode)
      `TPW_MODE_NORMAL, `TPW_MODE_CTC_A, `TPW_MODE_CTC_CAP: tpw_class_of = TPW_CL_NONPWM;
      `TPW_MODE_FP8, `TPW_MODE_FP9, `TPW_MODE_FP10, `TPW_MODE_FP_CAP, `TPW_MODE_FP_A: tpw_class_of = TPW_CL_FAST;
      `TPW_MODE_PC8, `TPW_MODE_PC9, `TPW_MODE_PC10, `TPW_MODE_PFC_CAP, `TPW_MODE_PFC_A,
      `TPW_MODE_PC_CAP, `TPW_MODE_PC_A: tpw_class_of = TPW_CL_DUAL;
      default: tpw_class_of = TPW_CL_RSVD;
    endcase
  endfunction : tpw_class_of

  function automatic tpw_upd_t tpw_upd_of(input logic [3:0] mode);
    if (mode == `TPW_MODE_PFC_CAP || mode == `TPW_MODE_PFC_A)
      tpw_upd_of = TPW_UPD_BOTTOM;
    else if (tpw_class_of(mode) == TPW_CL_NONPWM || tpw_class_of(mode) == TPW_CL_RSVD)
      tpw_upd_of = TPW_UPD_NOW;
    else
      tpw_upd_of = TPW_UPD_TOP;
  endfunction : tpw_upd_of

  function automatic logic [15:0] tpw_top_of(input logic [3:0] mode, input logic [15:0] cap,
                                             input logic [15:0] cmp_a);
    case (mode)
      `TPW_MODE_PC8, `TPW_MODE_FP8: tpw_top_of = `TPW_TOP_8BIT;
      `TPW_MODE_PC9, `TPW_MODE_FP9: tpw_top_of = `TPW_TOP_9BIT;
      `TPW_MODE_PC10, `TPW_MODE_FP10: tpw_top_of = `TPW_TOP_10BIT;
      `TPW_MODE_CTC_A, `TPW_MODE_PFC_A, `TPW_MODE_PC_A, `TPW_MODE_FP_A: tpw_top_of = cmp_a;
      `TPW_MODE_PFC_CAP, `TPW_MODE_PC_CAP, `TPW_MODE_CTC_CAP, `TPW_MODE_FP_CAP: tpw_top_of = cap;
      default: tpw_top_of = `TPW_TOP_MAX;
    endcase
  endfunction : tpw_top_of

  function automatic logic tpw_cap_is_top(input logic [3:0] mode);
    tpw_cap_is_top = (mode == `TPW_MODE_PFC_CAP) || (mode == `TPW_MODE_PC_CAP) ||
                     (mode == `TPW_MODE_CTC_CAP) || (mode == `TPW_MODE_FP_CAP);
  endfunction : tpw_cap_is_top

endpackage : tpw_pkg

// >>> rtl/tpw_prescaler.sv
`timescale 1ns/1ps
`include "tpw_defs.svh"

module tpw_prescaler (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Divider select and tick
  input wire logic [2:0] clk_sel,
  output logic tick
);

  tpw_pkg::tpw_pre_t st_reg;
  tpw_pkg::tpw_pre_t st_next;

  // The divider runs free, so changing the ratio never waits for a long count to drain.
  always_comb
  begin
    st_next = st_reg;
    st_next.div = 10'(st_reg.div + 10'h001);
    case (clk_sel)
      `TPW_CS_DIV1: st_next.tick = 1'b1;
      `TPW_CS_DIV8: st_next.tick = (st_reg.div & `TPW_PS_MASK_8) == `TPW_PS_MASK_8;
      `TPW_CS_DIV64: st_next.tick = (st_reg.div & `TPW_PS_MASK_64) == `TPW_PS_MASK_64;
      `TPW_CS_DIV256: st_next.tick = (st_reg.div & `TPW_PS_MASK_256) == `TPW_PS_MASK_256;
      `TPW_CS_DIV1024: st_next.tick = (st_reg.div & `TPW_PS_MASK_1024) == `TPW_PS_MASK_1024;
      default: st_next.tick = 1'b0;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      st_reg <= '{div: `TPW_PS_RST, tick: 1'b0};
    else
      st_reg <= st_next;
  end

  assign tick = st_reg.tick;

  div8_spacing_a: assert property (@(posedge mclk) disable iff (reset)
    tick && clk_sel == `TPW_CS_DIV8 |=> (!tick || clk_sel != `TPW_CS_DIV8) [*7])
    else $error("tick came early at divide by eight");

endmodule : tpw_prescaler

// >>> rtl/tpw_compare_ch.sv
`timescale 1ns/1ps
`include "tpw_defs.svh"

module tpw_compare_ch #(
  parameter logic CHAN_A = 1'b0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Software write
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  // Counter view
  input wire logic tick,
  input wire logic [3:0] mode,
  input wire logic [1:0] action,
  input wire logic [15:0] count,
  input wire logic [15:0] top,
  input wire logic slope_up,
  input wire logic at_top,
  input wire logic at_bottom,
  // Channel results
  output logic [15:0] active_val,
  output logic [15:0] buf_val,
  output logic oc,
  output logic drives,
  output logic hit
);

  tpw_pkg::tpw_chan_t st_reg;
  tpw_pkg::tpw_chan_t st_next;
  tpw_pkg::tpw_class_t cls;
  tpw_pkg::tpw_upd_t upd;
  logic toggle_ok;

  assign cls = tpw_pkg::tpw_class_of(mode);
  assign upd = tpw_pkg::tpw_upd_of(mode);
  assign hit = tick && count == st_reg.active;
  assign toggle_ok = (cls == tpw_pkg::TPW_CL_NONPWM) ||
                     (CHAN_A && (mode == `TPW_MODE_FP_CAP || mode == `TPW_MODE_FP_A)) ||
                     (CHAN_A && mode >= `TPW_MODE_PFC_CAP && mode <= `TPW_MODE_PC_A);
  // Action 01 where no toggle exists leaves the pin with the port, like action 00.
  assign drives = action != `TPW_ACT_OFF && !(action == `TPW_ACT_TOGGLE && !toggle_ok);

  always_comb
  begin
    st_next = st_reg;
    if (wr_en)
    begin
      st_next.buffer = wr_data;
      if (upd == tpw_pkg::TPW_UPD_NOW)
        st_next.active = wr_data;
    end
    if (tick && ((upd == tpw_pkg::TPW_UPD_TOP && at_top) || (upd == tpw_pkg::TPW_UPD_BOTTOM && at_bottom)))
      st_next.active = st_reg.buffer;
    if (action == `TPW_ACT_TOGGLE && toggle_ok && hit)
      st_next.oc = !st_reg.oc;
    else if (action[1])
    begin
      unique case (cls)
        tpw_pkg::TPW_CL_NONPWM:
          if (hit)
            st_next.oc = action[0];
        tpw_pkg::TPW_CL_FAST:
          if (tick && at_top)
            st_next.oc = !action[0];
          else if (hit && st_reg.active != top)
            st_next.oc = action[0];
        tpw_pkg::TPW_CL_DUAL:
          if (hit)
            st_next.oc = slope_up ? action[0] : !action[0];
        tpw_pkg::TPW_CL_RSVD:
          st_next.oc = st_reg.oc;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      st_reg <= '{buffer: `TPW_WORD_RST, active: `TPW_WORD_RST, oc: 1'b0};
    else
      st_reg <= st_next;
  end

  assign active_val = st_reg.active;
  assign buf_val = st_reg.buffer;
  assign oc = st_reg.oc;

endmodule : tpw_compare_ch

// >>> rtl/tpw_top.sv
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "tpw_defs.svh"

module tpw_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Port fallback levels and pin directions
  input wire logic port_a_data,
  input wire logic port_b_data,
  input wire logic out_pin_direction_a,
  input wire logic out_pin_direction_b,
  // Compare output pins
  output logic compare_out_a,
  output logic compare_out_a_oe,
  output logic compare_out_b,
  output logic compare_out_b_oe
);

  // ****************************************************************
  // State and decode
  // ****************************************************************
  tpw_pkg::tpw_main_t st_reg;
  tpw_pkg::tpw_main_t st_next;
  tpw_pkg::tpw_class_t cls;
  logic [3:0] waveform_mode_sel;
  logic [1:0] out_a_action;
  logic [1:0] out_b_action;
  logic [15:0] top_val;
  logic timer_tick;
  logic at_top;
  logic at_bottom;
  logic slope_up;
  logic wr_cmp_a;
  logic wr_cmp_b;
  logic [15:0] cmp_a_active;
  logic [15:0] cmp_a_buf;
  logic [15:0] cmp_b_active;
  logic [15:0] cmp_b_buf;
  logic oc_a;
  logic oc_b;
  logic drives_a;
  logic drives_b;
  logic hit_a;
  logic hit_b;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;

  assign waveform_mode_sel = {st_reg.ctrl_b[`TPW_CB_MODE_HI], st_reg.ctrl_a[`TPW_CA_MODE_LO]};
  assign out_a_action = st_reg.ctrl_a[`TPW_CA_ACT_A];
  assign out_b_action = st_reg.ctrl_a[`TPW_CA_ACT_B];
  assign cls = tpw_pkg::tpw_class_of(waveform_mode_sel);
  assign top_val = tpw_pkg::tpw_top_of(waveform_mode_sel, st_reg.capture_top, cmp_a_active);
  assign at_top = st_reg.count == top_val;
  assign at_bottom = st_reg.count == `TPW_BOTTOM;
  // Zero counts as the rising slope and TOP as the falling one, so the extreme compare
  // values settle to a steady level instead of glitching once a period.
  assign slope_up = at_bottom || (!at_top && st_reg.dir == tpw_pkg::TPW_UP);
  assign wr_cmp_a = reg_wr && reg_addr == `TPW_ADDR_CMP_A;
  assign wr_cmp_b = reg_wr && reg_addr == `TPW_ADDR_CMP_B;

  // ****************************************************************
  // Tick source and compare channels
  // ****************************************************************
  tpw_prescaler u_prescaler (
    .mclk(mclk),
    .reset(reset),
    .clk_sel(st_reg.ctrl_b[`TPW_CB_CLKSEL]),
    .tick(timer_tick)
  );

  tpw_compare_ch #(.CHAN_A(1'b1)) u_chan_a (
    .mclk(mclk),
    .reset(reset),
    .wr_en(wr_cmp_a),
    .wr_data(reg_wdata),
    .tick(timer_tick),
    .mode(waveform_mode_sel),
    .action(out_a_action),
    .count(st_reg.count),
    .top(top_val),
    .slope_up(slope_up),
    .at_top(at_top),
    .at_bottom(at_bottom),
    .active_val(cmp_a_active),
    .buf_val(cmp_a_buf),
    .oc(oc_a),
    .drives(drives_a),
    .hit(hit_a)
  );

  tpw_compare_ch #(.CHAN_A(1'b0)) u_chan_b (
    .mclk(mclk),
    .reset(reset),
    .wr_en(wr_cmp_b),
    .wr_data(reg_wdata),
    .tick(timer_tick),
    .mode(waveform_mode_sel),
    .action(out_b_action),
    .count(st_reg.count),
    .top(top_val),
    .slope_up(slope_up),
    .at_top(at_top),
    .at_bottom(at_bottom),
    .active_val(cmp_b_active),
    .buf_val(cmp_b_buf),
    .oc(oc_b),
    .drives(drives_b),
    .hit(hit_b)
  );

  // ****************************************************************
  // Flag events
  // ****************************************************************
  always_comb
  begin
    flag_set = `TPW_FLAGS_RST;
    flag_set[`TPW_FLG_CMPA] = hit_a;
    flag_set[`TPW_FLG_CMPB] = hit_b;
    flag_set[`TPW_FLG_CAPT] = timer_tick && at_top && tpw_pkg::tpw_cap_is_top(waveform_mode_sel);
    unique case (cls)
      tpw_pkg::TPW_CL_NONPWM: flag_set[`TPW_FLG_OVF] = timer_tick && st_reg.count == `TPW_TOP_MAX;
      tpw_pkg::TPW_CL_FAST: flag_set[`TPW_FLG_OVF] = timer_tick && at_top;
      tpw_pkg::TPW_CL_DUAL: flag_set[`TPW_FLG_OVF] = timer_tick && at_bottom;
      tpw_pkg::TPW_CL_RSVD: flag_set[`TPW_FLG_OVF] = 1'b0;
    endcase
  end

  assign flag_clr = (reg_wr && reg_addr == `TPW_ADDR_FLAGS) ? reg_wdata[3:0] : `TPW_FLAGS_RST;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    st_next = st_reg;
    if (reg_wr)
    begin
      unique case (reg_addr)
        `TPW_ADDR_CTRL_A:
        begin
          st_next.ctrl_a = reg_wdata[7:0];
          st_next.ctrl_a[`TPW_CA_RSVD] = 2'h0;
        end
        `TPW_ADDR_CTRL_B: st_next.ctrl_b = reg_wdata[4:0];
        `TPW_ADDR_CAPTOP: st_next.capture_top = reg_wdata;
        default: st_next.ctrl_b = st_reg.ctrl_b;
      endcase
    end

    // Counting moves only on the prescaled tick; the rest of the time it holds.
    if (timer_tick)
    begin
      unique case (cls)
        tpw_pkg::TPW_CL_DUAL:
          if (st_reg.dir == tpw_pkg::TPW_UP)
          begin
            // A count above a lowered TOP turns round at once rather than running to wrap.
            if (st_reg.count >= top_val)
            begin
              st_next.dir = tpw_pkg::TPW_DOWN;
              if (!at_bottom)
                st_next.count = 16'(st_reg.count - `TPW_ONE);
            end
            else
              st_next.count = 16'(st_reg.count + `TPW_ONE);
          end
          else if (at_bottom)
          begin
            st_next.dir = tpw_pkg::TPW_UP;
            st_next.count = 16'(st_reg.count + `TPW_ONE);
          end
          else
            st_next.count = 16'(st_reg.count - `TPW_ONE);
        tpw_pkg::TPW_CL_NONPWM, tpw_pkg::TPW_CL_FAST:
        begin
          st_next.dir = tpw_pkg::TPW_UP;
          st_next.count = (st_reg.count >= top_val) ? `TPW_BOTTOM : 16'(st_reg.count + `TPW_ONE);
        end
        tpw_pkg::TPW_CL_RSVD: st_next.count = st_reg.count;
      endcase
    end

    // A flag raised in the cycle software clears it survives the clear.
    st_next.flags = (st_reg.flags & ~flag_clr) | flag_set;

    st_next.rdata = `TPW_WORD_RST;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `TPW_ADDR_CTRL_A: st_next.rdata = {8'h00, st_reg.ctrl_a};
        `TPW_ADDR_CTRL_B: st_next.rdata = {11'h000, st_reg.ctrl_b};
        `TPW_ADDR_COUNT: st_next.rdata = st_reg.count;
        `TPW_ADDR_CMP_A: st_next.rdata = cmp_a_buf;
        `TPW_ADDR_CMP_B: st_next.rdata = cmp_b_buf;
        `TPW_ADDR_CAPTOP: st_next.rdata = st_reg.capture_top;
        `TPW_ADDR_FLAGS: st_next.rdata = {12'h000, st_reg.flags};
        default: st_next.rdata = `TPW_WORD_RST;
      endcase
    end

    // The pin sees the compare level only while the channel is connected.
    st_next.pin_a = drives_a ? oc_a : port_a_data;
    st_next.pin_b = drives_b ? oc_b : port_b_data;
    st_next.pin_a_oe = out_pin_direction_a;
    st_next.pin_b_oe = out_pin_direction_b;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      st_reg <= '{ctrl_a: `TPW_CTRL_A_RST, ctrl_b: `TPW_CTRL_B_RST, count: `TPW_WORD_RST,
                  dir: tpw_pkg::TPW_UP, capture_top: `TPW_WORD_RST, flags: `TPW_FLAGS_RST,
                  rdata: `TPW_WORD_RST, pin_a: 1'b0, pin_a_oe: 1'b0, pin_b: 1'b0, pin_b_oe: 1'b0};
    else
      st_reg <= st_next;
  end

  assign reg_rdata = st_reg.rdata;
  assign compare_out_a = st_reg.pin_a;
  assign compare_out_a_oe = st_reg.pin_a_oe;
  assign compare_out_b = st_reg.pin_b;
  assign compare_out_b_oe = st_reg.pin_b_oe;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  top_select_a: assert property (
    (waveform_mode_sel == `TPW_MODE_PFC_CAP |-> top_val == st_reg.capture_top) and
    (waveform_mode_sel == `TPW_MODE_PFC_A |-> top_val == cmp_a_active))
    else $error("top source does not follow the waveform mode");

  top_turn_a: assert property (
    timer_tick && cls == tpw_pkg::TPW_CL_DUAL && st_reg.dir == tpw_pkg::TPW_UP && at_top && !at_bottom
    |=> st_reg.count == 16'($past(top_val) - `TPW_ONE) && st_reg.dir == tpw_pkg::TPW_DOWN)
    else $error("count did not leave top after one tick");

  bottom_turn_a: assert property (
    timer_tick && cls == tpw_pkg::TPW_CL_DUAL && st_reg.dir == tpw_pkg::TPW_DOWN && at_bottom
    |=> st_reg.count == `TPW_ONE && st_reg.dir == tpw_pkg::TPW_UP)
    else $error("count did not turn upward at zero");

  tick_only_a: assert property (
    !timer_tick |=> $stable(st_reg.count))
    else $error("count moved without a timer tick");

  pfc_overflow_a: assert property (
    timer_tick && at_bottom && waveform_mode_sel inside {`TPW_MODE_PFC_CAP, `TPW_MODE_PFC_A}
    |=> st_reg.flags[`TPW_FLG_OVF] && cmp_a_active == $past(cmp_a_buf) && cmp_b_active == $past(cmp_b_buf))
    else $error("zero point did not load compares and raise overflow");

  pfc_hold_a: assert property (
    waveform_mode_sel inside {`TPW_MODE_PFC_CAP, `TPW_MODE_PFC_A} && !(timer_tick && at_bottom)
    && $stable(waveform_mode_sel) |=> $stable(cmp_b_active))
    else $error("compare value applied mid period");

  cap_top_flag_a: assert property (
    timer_tick && at_top && waveform_mode_sel == `TPW_MODE_PFC_CAP |=> st_reg.flags[`TPW_FLG_CAPT])
    else $error("capture flag missing at top");

  match_flag_a: assert property (
    timer_tick && st_reg.count == cmp_b_active |=> st_reg.flags[`TPW_FLG_CMPB])
    else $error("match flag not set on equality");

  dual_clear_a: assert property (
    hit_a && cls == tpw_pkg::TPW_CL_DUAL && out_a_action == `TPW_ACT_CLEAR && slope_up && !reg_wr
    |=> !oc_a ##1 (!drives_a || !compare_out_a))
    else $error("up slope match did not clear channel a");

  ctrl_a_zero_a: assert property (
    reg_rd && reg_addr == `TPW_ADDR_CTRL_A |=> reg_rdata[15:8] == 8'h00 && reg_rdata[`TPW_CA_RSVD] == 2'h0)
    else $error("reserved control bits read nonzero");

  b_toggle_off_a: assert property (
    cls == tpw_pkg::TPW_CL_DUAL && out_b_action == `TPW_ACT_TOGGLE && !reg_wr
    |=> ##1 compare_out_b == $past(port_b_data))
    else $error("channel b toggle reached the pin");

  pin_override_a: assert property (
    out_a_action == `TPW_ACT_OFF && !reg_wr |=> compare_out_a == $past(port_a_data)
    && compare_out_a_oe == $past(out_pin_direction_a))
    else $error("pin not under port control");

  pfc_top_seen_c: cover property (
    waveform_mode_sel == `TPW_MODE_PFC_A && timer_tick && at_top && !at_bottom);
  overflow_seen_c: cover property (
    timer_tick && at_bottom && cls == tpw_pkg::TPW_CL_DUAL ##[1:1000] st_reg.flags[`TPW_FLG_OVF]);
  toggle_a_seen_c: cover property (
    hit_a && out_a_action == `TPW_ACT_TOGGLE && drives_a);
  pin_b_driven_c: cover property (
    compare_out_b_oe && drives_b && $rose(compare_out_b));

endmodule : tpw_top

// >>> dv/tpw_load_model.sv
`timescale 1ns/1ps

module tpw_load_model (
  // Pin side
  input wire logic pin,
  input wire logic pin_oe,
  // Level seen by the power stage
  output logic line
);
  // The stage input has a pull-down, so a released pin never shows its last driven level.
  assign line = pin_oe ? pin : 1'b0;
endmodule : tpw_load_model

// >>> dv/tpw_top_tb.sv
`timescale 1ns/1ps
`include "tpw_defs.svh"

module tpw_top_tb;
  logic mclk;
  logic reset;
  logic [2:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic port_a_data;
  logic port_b_data;
  logic out_pin_direction_a;
  logic out_pin_direction_b;
  logic out_a;
  logic out_a_oe;
  logic out_b;
  logic out_b_oe;
  logic line_a;
  logic line_b;
  logic [15:0] rd_val;
  int num_errors;
  int check_count;

  tpw_top dut_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_a_data(port_a_data), .port_b_data(port_b_data),
    .out_pin_direction_a(out_pin_direction_a), .out_pin_direction_b(out_pin_direction_b),
    .compare_out_a(out_a), .compare_out_a_oe(out_a_oe), .compare_out_b(out_b), .compare_out_b_oe(out_b_oe));
  tpw_load_model load_a_u (.pin(out_a), .pin_oe(out_a_oe), .line(line_a));
  tpw_load_model load_b_u (.pin(out_b), .pin_oe(out_b_oe), .line(line_b));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic finish_test();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [2:0] addr, input logic [15:0] data);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= addr;
    reg_wdata <= data;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] addr, output logic [15:0] data);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= addr;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 data = reg_rdata;
  endtask : rd

  // Mode 0 is entered first so that compare writes land at once; in PWM modes they would wait for TOP, or for zero in modes 8 and 9.
  task automatic run(input logic [7:0] ctl_a, input logic [15:0] ctl_b, input logic [15:0] cap,
    input logic [15:0] cmp_a, input logic [15:0] cmp_b, input int win, input int exp_a, input int exp_b);
    logic [15:0] hi_a;
    logic [15:0] hi_b;
    hi_a = 16'h0000;
    hi_b = 16'h0000;
    wr(`TPW_ADDR_CTRL_B, 16'h0000);
    wr(`TPW_ADDR_CTRL_A, 16'h0000);
    wr(`TPW_ADDR_CAPTOP, cap);
    wr(`TPW_ADDR_CMP_A, cmp_a);
    wr(`TPW_ADDR_CMP_B, cmp_b);
    wr(`TPW_ADDR_CTRL_A, {8'h00, ctl_a});
    wr(`TPW_ADDR_CTRL_B, ctl_b);
    repeat (200) @(posedge mclk);
    // Pins are sampled mid-cycle, away from the edge that launches them; an unknown level poisons the sum.
    repeat (win)
    begin
      @(negedge mclk);
      hi_a = 16'(hi_a + {15'h0000, line_a});
      hi_b = 16'(hi_b + {15'h0000, line_b});
    end
    chk("pin a high cycles", exp_a[15:0], hi_a);
    chk("pin b high cycles", exp_b[15:0], hi_b);
  endtask : run

  // ****************************************************************
  // Stimulus and checks
  // ****************************************************************
  initial
  begin
    reset = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    port_a_data = 1'b1;
    port_b_data = 1'b1;
    out_pin_direction_a = 1'b1;
    out_pin_direction_b = 1'b1;
    num_errors = 0;
    check_count = 0;
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    rd(`TPW_ADDR_CTRL_A, rd_val);
    chk("ctrl a reset", 16'h0000, rd_val);
    wr(`TPW_ADDR_CTRL_A, 16'h00ff);
    rd(`TPW_ADDR_CTRL_A, rd_val);
    chk("ctrl a readback", 16'h00f3, rd_val);
    rd(3'h7, rd_val);
    chk("unmapped read", 16'h0000, rd_val);
    // TOP of 0x0010 and above 0x0003 keeps every compare at or below TOP except the deliberate one.
    run(8'h20, 16'h0011, 16'h0010, 16'h0020, 16'h0004, 32, 32, 8);
    wr(`TPW_ADDR_FLAGS, 16'h000f);
    repeat (40) @(posedge mclk);
    rd(`TPW_ADDR_FLAGS, rd_val);
    chk("flags after period", 16'h000d, rd_val);
    @(posedge mclk);
    out_pin_direction_b <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk("pin b released", 16'h0000, {14'h0000, out_b_oe, line_b});
    @(posedge mclk);
    out_pin_direction_b <= 1'b1;
    run(8'h30, 16'h0011, 16'h0010, 16'h0020, 16'h0004, 32, 32, 24);
    run(8'ha0, 16'h0011, 16'h0010, 16'h0008, 16'h0000, 32, 16, 0);
    run(8'h20, 16'h0011, 16'h0010, 16'h0020, 16'h0010, 32, 32, 32);
    // Port B goes low so that a channel B compare level leaking onto the pin would show.
    @(posedge mclk);
    port_b_data <= 1'b0;
    run(8'h51, 16'h0011, 16'h0030, 16'h0010, 16'h0004, 64, 32, 0);
    @(posedge mclk);
    port_b_data <= 1'b1;
    run(8'h20, 16'h0012, 16'h0004, 16'h0020, 16'h0001, 64, 64, 16);
    run(8'h22, 16'h0019, 16'h0010, 16'h0020, 16'h0004, 17, 17, 5);
    run(8'h22, 16'h0019, 16'h0010, 16'h0020, 16'h0010, 17, 17, 17);
    run(8'h10, 16'h0019, 16'h0010, 16'h0020, 16'h0004, 34, 34, 17);
    run(8'h20, 16'h0019, 16'h0010, 16'h0020, 16'h0004, 34, 34, 0);
    run(8'h30, 16'h0019, 16'h0010, 16'h0020, 16'h0004, 34, 34, 34);
    run(8'h43, 16'h0019, 16'h0010, 16'h0010, 16'h0004, 34, 17, 34);
    run(8'h43, 16'h0011, 16'h0010, 16'h0010, 16'h0004, 64, 32, 64);
    finish_test();
  end

  initial
  begin
    repeat (100000) @(posedge mclk);
    num_errors++;
    finish_test();
  end
endmodule : tpw_top_tb
